// file: design/mcjd_pkg.sv
// package: constants and carriers for the conditional jump decoder
// Behaviour
// - control-bit relative jump: opcode 001000, fields
// - jump only when selected bit matches level
// - selector 0..15 picks control bit 0..15
// - control bits from executing core's register
// - level 0 tests for 0, 1 for 1
// - relative target is own address plus offset
// - offset is signed five bits, -16..15
// - absolute feedback jump: 001110, low nibble 0100
// - absolute target comes from selected jump register
// - absolute target reaches any code location
// - codes 0..9: high-side drain-source, source pairs
// - codes 10..15: low-side drivers 1..6 drain-source
// - feedback jump only when level matches
// - relative feedback jump: opcode 000101, fields
// - relative feedback target like other relatives
package mcjd_pkg;
   localparam int CA_W = 10;
   localparam int FB_W = 16;
   // opcodes and instruction field positions
   localparam logic [5:0] OPC_CRR = 6'h08;
   localparam logic [5:0] OPC_FBF = 6'h0e;
   localparam logic [3:0] SUB_FBF = 4'h4;
   localparam logic [5:0] OPC_FBR = 6'h05;
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 10;
   localparam int CRR_POL = 9;
   localparam int CRR_SEL_MSB = 8;
   localparam int CRR_SEL_LSB = 5;
   localparam int FB_SEL_MSB = 9;
   localparam int FB_SEL_LSB = 6;
   localparam int FB_POL = 5;
   localparam int FBF_JR = 4;
   localparam int SUB_MSB = 3;
   localparam int OFF_MSB = 4;
   // register byte addresses; control registers sit at four times their index
   localparam logic [11:0] ADR_JREG0 = 12'h000;
   localparam logic [11:0] ADR_JREG1 = 12'h004;
   localparam logic [11:0] ADR_CFG = 12'h008;
   localparam logic [11:0] ADR_STAT = 12'h00c;
   localparam logic [11:0] ADR_FB = 12'h010;
   localparam logic [11:0] IDX_CORE0_A = 12'h101;
   localparam logic [11:0] IDX_CORE1_A = 12'h102;
   localparam logic [11:0] IDX_CORE0_B = 12'h121;
   localparam logic [11:0] IDX_CORE1_B = 12'h122;
   localparam logic [3:0][11:0] ADR_CTRL = {12'(IDX_CORE1_B * 4), 12'(IDX_CORE0_B * 4),
                                            12'(IDX_CORE1_A * 4), 12'(IDX_CORE0_A * 4)};
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // values after reset
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [CA_W-1:0] RST_JREG = 10'h000;
   localparam logic [CA_W-1:0] RST_PC = 10'h000;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_CRR = 2'b01,
      OP_FBF = 2'b10,
      OP_FBR = 2'b11
   } mcjd_op_t;

   typedef struct packed {
      logic            valid;
      logic [CA_W-1:0] addr;
      logic [15:0]     word;
   } mcjd_fetch_t;

   typedef struct packed {
      logic            valid;
      logic            hit;
      logic            taken;
      logic [CA_W-1:0] pc;
   } mcjd_result_t;

   typedef struct packed {
      logic [3:0][15:0]     ctrl;
      logic [1:0][CA_W-1:0] jreg;
      logic                 core_sel;
      logic                 bank_sel;
      logic                 wpend;
      logic [11:0]          waddr;
      logic [31:0]          rdata;
      logic                 ready;
      mcjd_result_t         res;
   } mcjd_state_t;

   typedef struct packed {
      logic [FB_W-1:0] meta;
      logic [FB_W-1:0] sync;
   } mcjd_sync_t;
endpackage : mcjd_pkg

// file: design/mcjd_sync.sv
// two-flop synchroniser for the driver feedback pins
`timescale 1ns/10ps
module mcjd_sync (
   input  wire logic                       mclk,
   input  wire logic                       reset,
   input  wire logic [mcjd_pkg::FB_W-1:0]  fb_async,
   output logic      [mcjd_pkg::FB_W-1:0]  fb_sync
);
   mcjd_pkg::mcjd_sync_t q;
   mcjd_pkg::mcjd_sync_t d;

   always_comb begin
      d = q;
      d.meta = fb_async;
      // first stage feeds nothing but the second
      d.sync = q.meta;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign fb_sync = q.sync;

   a_sync_two_flops: assert property (@(posedge mclk) disable iff (reset)
      !$past(reset, 2) |-> fb_sync == $past(fb_async, 2))
      else $error("feedback not delayed by two flops");
endmodule : mcjd_sync

// file: design/mcjd_top.sv
// conditional jump decoder with its ahb-lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module mcjd_top (
   input  wire logic                         mclk,
   input  wire logic                         reset,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic      [31:0]                  hrdata,
   input  mcjd_pkg::mcjd_fetch_t             fetch,
   input  wire logic [mcjd_pkg::FB_W-1:0]    fb_pins,
   output mcjd_pkg::mcjd_result_t            result
);
   mcjd_pkg::mcjd_state_t           q;
   mcjd_pkg::mcjd_state_t           d;
   mcjd_pkg::mcjd_op_t              op;
   logic [mcjd_pkg::FB_W-1:0]       fb_sync;
   logic [15:0]                     ctrl_now;
   logic                            crr_cond;
   logic                            fb_cond;
   logic [mcjd_pkg::CA_W-1:0]       rel_pc;
   logic [mcjd_pkg::CA_W-1:0]       abs_pc;
   logic [mcjd_pkg::CA_W-1:0]       seq_pc;
   logic                            aph;
   logic                            mapped;

   // pins cross in through two flops before the decoder looks at them
   mcjd_sync u_sync (
      .mclk     (mclk),
      .reset    (reset),
      .fb_async (fb_pins),
      .fb_sync  (fb_sync)
   );

   function automatic mcjd_pkg::mcjd_op_t decode(logic [15:0] w);
      mcjd_pkg::mcjd_op_t o;
      o = mcjd_pkg::OP_NONE;
      if (w[mcjd_pkg::OPC_MSB:mcjd_pkg::OPC_LSB] == mcjd_pkg::OPC_CRR) begin
         o = mcjd_pkg::OP_CRR;
      end else if (w[mcjd_pkg::OPC_MSB:mcjd_pkg::OPC_LSB] == mcjd_pkg::OPC_FBF &&
                   w[mcjd_pkg::SUB_MSB:0] == mcjd_pkg::SUB_FBF) begin
         o = mcjd_pkg::OP_FBF;
      end else if (w[mcjd_pkg::OPC_MSB:mcjd_pkg::OPC_LSB] == mcjd_pkg::OPC_FBR) begin
         o = mcjd_pkg::OP_FBR;
      end
      return o;
   endfunction : decode

   // reads see this cycle's write, so back-to-back write then read is coherent
   function automatic logic [31:0] rd_mux(mcjd_pkg::mcjd_state_t s, logic [11:0] a,
                                          logic [mcjd_pkg::FB_W-1:0] fb);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         mcjd_pkg::ADR_JREG0: r = 32'(s.jreg[0]);
         mcjd_pkg::ADR_JREG1: r = 32'(s.jreg[1]);
         mcjd_pkg::ADR_CFG:   r = {30'h0, s.bank_sel, s.core_sel};
         mcjd_pkg::ADR_STAT:  r = 32'(s.res);
         mcjd_pkg::ADR_FB:    r = 32'(fb);
         default:             r = 32'h0;
      endcase
      for (int i = 0; i < 4; i++) begin
         if (a == mcjd_pkg::ADR_CTRL[i]) begin
            r = {16'h0, s.ctrl[i]};
         end
      end
      return r;
   endfunction : rd_mux

   always_comb begin
      d = q;
      op = decode(fetch.word);
      // the executing core and bank pick one of the four control registers
      ctrl_now = q.ctrl[{q.bank_sel, q.core_sel}];
      crr_cond = ctrl_now[fetch.word[mcjd_pkg::CRR_SEL_MSB:mcjd_pkg::CRR_SEL_LSB]]
                 == fetch.word[mcjd_pkg::CRR_POL];
      // feedback index equals selector: 0..9 high-side pairs, 10..15 low-side
      fb_cond = fb_sync[fetch.word[mcjd_pkg::FB_SEL_MSB:mcjd_pkg::FB_SEL_LSB]]
                == fetch.word[mcjd_pkg::FB_POL];
      // sign-extend the offset; the sum wraps at the code address width
      rel_pc = fetch.addr + {{(mcjd_pkg::CA_W-5){fetch.word[mcjd_pkg::OFF_MSB]}},
                             fetch.word[mcjd_pkg::OFF_MSB:0]};
      abs_pc = q.jreg[fetch.word[mcjd_pkg::FBF_JR]];
      seq_pc = fetch.addr + mcjd_pkg::CA_W'(1);
      aph = hsel && htrans[1] && hready;
      mapped = haddr[31:12] == 20'h0;

      // data phase of a previously accepted write
      d.wpend = 1'b0;
      if (q.wpend) begin
         case (q.waddr)
            mcjd_pkg::ADR_JREG0: d.jreg[0] = hwdata[mcjd_pkg::CA_W-1:0];
            mcjd_pkg::ADR_JREG1: d.jreg[1] = hwdata[mcjd_pkg::CA_W-1:0];
            mcjd_pkg::ADR_CFG: begin
               d.core_sel = hwdata[0];
               d.bank_sel = hwdata[1];
            end
            default: d.core_sel = q.core_sel;
         endcase
         for (int i = 0; i < 4; i++) begin
            if (q.waddr == mcjd_pkg::ADR_CTRL[i]) begin
               d.ctrl[i] = hwdata[15:0];
            end
         end
      end

      // only whole-word writes are stored; others complete okay and are dropped
      if (aph && hwrite && mapped && hsize == mcjd_pkg::HSIZE_WORD) begin
         d.wpend = 1'b1;
         d.waddr = haddr[11:0];
      end

      // conditions are taken in the decode cycle itself
      d.res.valid = fetch.valid;
      d.res.hit = 1'b0;
      d.res.taken = 1'b0;
      d.res.pc = q.res.pc;
      if (fetch.valid) begin
         d.res.pc = seq_pc;
         case (op)
            mcjd_pkg::OP_CRR: begin
               d.res.hit = 1'b1;
               d.res.taken = crr_cond;
               if (crr_cond) begin
                  d.res.pc = rel_pc;
               end
            end
            mcjd_pkg::OP_FBF: begin
               d.res.hit = 1'b1;
               d.res.taken = fb_cond;
               if (fb_cond) begin
                  d.res.pc = abs_pc;
               end
            end
            mcjd_pkg::OP_FBR: begin
               d.res.hit = 1'b1;
               d.res.taken = fb_cond;
               if (fb_cond) begin
                  d.res.pc = rel_pc;
               end
            end
            default: d.res.hit = 1'b0;
         endcase
      end

      // zero wait states; unmapped reads return zero
      d.ready = 1'b1;
      d.rdata = 32'h0;
      if (aph && !hwrite && mapped) begin
         d.rdata = rd_mux(d, haddr[11:0], fb_sync);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         q.ctrl <= {4{mcjd_pkg::RST_CTRL}};
         q.jreg <= {2{mcjd_pkg::RST_JREG}};
         q.core_sel <= 1'b0;
         q.bank_sel <= 1'b0;
         q.wpend <= 1'b0;
         q.waddr <= 12'h000;
         q.rdata <= 32'h0;
         q.ready <= 1'b1;
         q.res <= '{valid: 1'b0, hit: 1'b0, taken: 1'b0, pc: mcjd_pkg::RST_PC};
      end else begin
         q <= d;
      end
   end

   assign hreadyout = q.ready;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign result = q.res;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_crr_decode_hit: assert property (
      fetch.valid && fetch.word[15:10] == 6'h08 |=> result.valid && result.hit)
      else $error("control-bit jump not recognised");

   a_crr_bit_match: assert property (
      fetch.valid && fetch.word[15:10] == 6'h08
      |=> result.taken == ($past(ctrl_now[fetch.word[8:5]]) == $past(fetch.word[9])))
      else $error("control-bit jump condition wrong");

   a_ctrl_reg_pick: assert property (
      fetch.valid && fetch.word[15:10] == 6'h08 && q.core_sel && !q.bank_sel
      |=> result.taken == ($past(q.ctrl[1][fetch.word[8:5]]) == $past(fetch.word[9])))
      else $error("wrong control register tested");

   a_rel_target_sum: assert property (
      fetch.valid && fetch.word[15:10] == 6'h08 && crr_cond
      |=> result.pc == 10'($past(fetch.addr) + {{5{$past(fetch.word[4])}}, $past(fetch.word[4:0])}))
      else $error("relative target wrong");

   a_fbf_abs_load: assert property (
      fetch.valid && fetch.word[15:10] == 6'h0e && fetch.word[3:0] == 4'h4 && fb_cond
      |=> result.taken && result.pc == $past(q.jreg[fetch.word[4]]))
      else $error("absolute target not from jump register");

   a_fb_level_match: assert property (
      fetch.valid && fetch.word[15:10] == 6'h05
      |=> result.hit && result.taken == ($past(fb_sync[fetch.word[9:6]]) == $past(fetch.word[5])))
      else $error("feedback condition wrong");

   a_fbr_back_jump: assert property (
      fetch.valid && fetch.word[15:10] == 6'h05 && fetch.word[4:0] == 5'h10 && fb_cond
      |=> result.pc == 10'($past(fetch.addr) - 10'h010))
      else $error("most negative offset not -16");

   a_untaken_next: assert property (
      fetch.valid && !(op != mcjd_pkg::OP_NONE && (op == mcjd_pkg::OP_CRR ? crr_cond : fb_cond))
      |=> !result.taken && result.pc == 10'($past(fetch.addr) + 10'h001))
      else $error("untaken jump did not advance");

   a_bus_zero_wait: assert property (
      hreadyout && !hresp)
      else $error("slave stalled or erred");

   c_crr_taken: cover property (fetch.valid && op == mcjd_pkg::OP_CRR && crr_cond);
   c_fbf_taken: cover property (fetch.valid && op == mcjd_pkg::OP_FBF && fb_cond);
   c_fbr_untaken: cover property (fetch.valid && op == mcjd_pkg::OP_FBR && !fb_cond);
endmodule : mcjd_top

// file: tb/mcjd_fetch_model.sv
// fetch-side model: sequencer program counter presenting instruction words
`timescale 1ns/10ps
module mcjd_fetch_model (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      issue,
   input  wire logic                      load,
   input  wire logic [mcjd_pkg::CA_W-1:0] load_addr,
   input  wire logic [15:0]               word,
   input  mcjd_pkg::mcjd_result_t         result,
   output mcjd_pkg::mcjd_fetch_t          fetch
);
   logic [mcjd_pkg::CA_W-1:0] pc_q;

   always @(posedge mclk) begin
      if (reset) begin
         pc_q <= '0;
         fetch <= '0;
      end else begin
         // follows the decoder's next address, as the real sequencer does
         if (load) begin
            pc_q <= load_addr;
         end else if (result.valid) begin
            pc_q <= result.pc;
         end
         fetch.valid <= issue;
         // idle fetch lines toggle so a stale word can never pass for a new one
         fetch.addr <= issue ? pc_q : ~fetch.addr;
         fetch.word <= issue ? word : ~fetch.word;
      end
   end
endmodule : mcjd_fetch_model

// file: tb/mcjd_bench.sv
// self-checking bench for the conditional jump decoder
`timescale 1ns/10ps
module mcjd_bench;
   localparam int TMO = 20000;
   logic                   mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, issue = 1'b0, load = 1'b0;
   logic                   hready, hreadyout, hresp;
   logic [31:0]            haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]             htrans = 2'h0;
   logic [2:0]             hsize = 3'h0;
   logic [15:0]            word = 16'h0, fb_pins = 16'h0;
   logic [9:0]             load_addr = 10'h0, pc_e = 10'h0;
   logic [15:0]            pats [4] = '{16'ha5c3, 16'h5a3c, 16'hf00f, 16'h0ff0};
   int                     n_errors = 0, checks = 0, cyc = 0;
   mcjd_pkg::mcjd_fetch_t  fetch;
   mcjd_pkg::mcjd_result_t result;

   assign hready = hreadyout;
   always #10 mclk = ~mclk;

   mcjd_top u_mcjd_top (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .fetch(fetch), .fb_pins(fb_pins), .result(result));
   mcjd_fetch_model u_mcjd_fetch_model (.mclk(mclk), .reset(reset), .issue(issue), .load(load),
      .load_addr(load_addr), .word(word), .result(result), .fetch(fetch));

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one single ahb-lite transfer; waits on hready in both phases
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= mcjd_pkg::HSIZE_WORD;
      // no local limit: only the bench timeout ends a stalled transfer
      do begin
         @(posedge mclk);
      end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge mclk);
      end while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(nm, e, v);
   endtask : rd_chk

   task automatic ld(input logic [9:0] a);
      @(posedge mclk);
      load <= 1'b1;
      load_addr <= a;
      @(posedge mclk);
      load <= 1'b0;
      pc_e = a;
   endtask : ld

   // issue one word at the model's pc; untaken means next location
   task automatic exec(input logic [15:0] w, input logic hit, input logic tk, input logic [9:0] tgt);
      logic [9:0] nx;
      nx = tk ? tgt : pc_e + 10'h1;
      @(posedge mclk);
      issue <= 1'b1;
      word <= w;
      @(posedge mclk);
      issue <= 1'b0;
      @(posedge mclk);
      #1;
      chk("result", {19'h0, 1'b1, hit, tk, nx}, 32'(result));
      pc_e = nx;
   endtask : exec

   function automatic logic [9:0] rel(input logic [4:0] o);
      return pc_e + {{5{o[4]}}, o};
   endfunction : rel

   function automatic logic [15:0] crr(input logic p, input logic [3:0] s, input logic [4:0] o);
      return {mcjd_pkg::OPC_CRR, p, s, o};
   endfunction : crr

   function automatic logic [15:0] fbf(input logic [3:0] s, input logic p, input logic j);
      return {mcjd_pkg::OPC_FBF, s, p, j, mcjd_pkg::SUB_FBF};
   endfunction : fbf

   function automatic logic [15:0] fbr(input logic [3:0] s, input logic p, input logic [4:0] o);
      return {mcjd_pkg::OPC_FBR, s, p, o};
   endfunction : fbr

   initial begin
      int c;
      int s;
      int i;
      logic t;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      chk("result_rst", 32'h0, 32'(result));
      for (c = 0; c < 4; c++) begin
         rd_chk("ctrl_rst", 32'(mcjd_pkg::ADR_CTRL[c]), 32'h0);
         wr(32'(mcjd_pkg::ADR_CTRL[c]), {16'hffff, pats[c]});
         rd_chk("ctrl", 32'(mcjd_pkg::ADR_CTRL[c]), {16'h0, pats[c]});
      end
      wr(32'(mcjd_pkg::ADR_JREG0), 32'hffff_ffff);
      wr(32'(mcjd_pkg::ADR_JREG1), 32'h0000_0155);
      rd_chk("jreg0", 32'(mcjd_pkg::ADR_JREG0), 32'h0000_03ff);
      rd_chk("jreg1", 32'(mcjd_pkg::ADR_JREG1), 32'h0000_0155);
      wr(32'h0000_1000, 32'h0000_1234);
      rd_chk("unmapped", 32'h0000_1000, 32'h0);
      // the dropped write must not alias onto the low register
      rd_chk("jreg0_kept", 32'(mcjd_pkg::ADR_JREG0), 32'h0000_03ff);
      // every core/bank pairing, every bit, both levels, offsets -8..-9 wrapping
      for (c = 0; c < 4; c++) begin
         wr(32'(mcjd_pkg::ADR_CFG), 32'(c));
         for (s = 0; s < 32; s++) begin
            t = pats[c][s[4:1]] == s[0];
            exec(crr(s[0], s[4:1], 5'(s - 8)), 1'b1, t, rel(5'(s - 8)));
         end
      end
      ld(10'h005);
      exec(crr(1'b0, 4'h0, 5'h10), 1'b1, 1'b1, 10'h3f5);
      ld(10'h3fa);
      exec(crr(1'b0, 4'h0, 5'h0f), 1'b1, 1'b1, 10'h009);
      for (i = 0; i < 16; i++) begin
         @(posedge mclk);
         fb_pins <= 16'h1 << i;
         repeat (3) @(posedge mclk);
         rd_chk("fb", 32'(mcjd_pkg::ADR_FB), 32'h1 << i);
         exec(fbr(4'(i), 1'b1, 5'(i + 9)), 1'b1, 1'b1, rel(5'(i + 9)));
         exec(fbr(4'(i + 1), 1'b1, 5'h01), 1'b1, 1'b0, 10'h0);
         exec(fbf(4'(i + 1), 1'b0, i[0]), 1'b1, 1'b1, i[0] ? 10'h155 : 10'h3ff);
         exec(fbf(4'(i), 1'b0, i[0]), 1'b1, 1'b0, 10'h0);
      end
      exec(16'h0000, 1'b0, 1'b0, 10'h0);
      exec({mcjd_pkg::OPC_FBF, 4'h0, 1'b1, 1'b0, 4'h5}, 1'b0, 1'b0, 10'h0);
      // status keeps the last pc with the one-cycle flags already gone
      rd_chk("stat", 32'(mcjd_pkg::ADR_STAT), {22'h0, pc_e});
      print_verdict();
   end
endmodule : mcjd_bench
